/* src/dscu_map.vh */
// register offsets, command codes and response words of the debug unit
`ifndef DSCU_MAP_VH
`define DSCU_MAP_VH
// serial frame: one status bit above a 16-bit word
`define DSCU_FRAME_BITS 5'h11
// command words and fields
`define DSCU_CMD_NOP 16'h0000
`define DSCU_CMD_SYNC 16'h0001
`define DSCU_CMD_GO 16'h0C00
`define DSCU_CMD_RCREG 16'h2980
`define DSCU_FILL_HI 8'h1C
`define DSCU_SIZE_MSB 7
`define DSCU_SIZE_LSB 6
`define DSCU_SIZE_BYTE 2'h0
`define DSCU_SIZE_WORD 2'h1
`define DSCU_SIZE_LONG 2'h2
// response frames: status bit then data
`define DSCU_RSP_DONE 17'h0FFFF
`define DSCU_RSP_BUSERR 17'h10001
`define DSCU_RSP_ILLEGAL 17'h1FFFF
`define DSCU_RSP_NOTREADY 17'h10000
// control select codes
`define DSCU_SEL_OTHER_SP 12'h800
`define DSCU_SEL_LOAD_SP 12'h08F
`define DSCU_SEL_STORE_SP 12'h18F
// trace status codes
`define DSCU_TRC_IDLE 4'h0
`define DSCU_TRC_TAKEN 4'h5
`define DSCU_TRC_MARK_BASE 4'h8
// avalon word addresses
`define DSCU_ADR_CTRL 3'h0
`define DSCU_ADR_STATUS 3'h1
`define DSCU_ADR_PTR 3'h2
`define DSCU_ADR_SP_ACT 3'h3
`define DSCU_ADR_SP_INACT 3'h4
// reset values
`define DSCU_CTRL_RST 2'h3
`define DSCU_SP_RST 32'h00000000
`endif

/* src/dscu_top.v */
// command decoder of the background debug serial port
`timescale 1ns/1ps
// How it works
// - fill writes operand at pointer, advances on success
// - fill legal only after fill, no-op, write
// - no-op leaves the fill pointer alone
// - fill size decoded anew every command
// - fill answers done, or error word on fault
// - resume while halted restarts the core
// - resume while running is ignored
// - resume returns done on next shift
// - no-op changes nothing, returns done
// - pc sync raises request, core captures pc
// - trace marker by byte count, then address
// - pc sync returns done when finished
// - control read: 32-bit select, 32-bit data
// - 12-bit select, same as move-to-control
// - control data returned high word first
// - data and address register select ranges
// - inactive sp, status, pc codes
// - multiply-accumulate register codes
// - gpio, flash, ram base register codes
// - active and inactive 32-bit stack pointers
`include "dscu_map.vh"
module dscu_top #(
  parameter AW = 3
) (
  input wire clk_i,
  input wire srst_i,
  // serial link
  input wire dsclk_i,
  input wire dsi_i,
  output reg dso_o,
  // neighbour commands
  input wire ext_cmd_busy_i,
  input wire ext_write_done_i,
  input wire [31:0] ext_next_addr_i,
  // core
  input wire halted_i,
  input wire supervisor_bit_i,
  output reg resume_o,
  output reg pc_sync_req_o,
  input wire pc_capture_i,
  input wire [31:0] pc_capture_addr_i,
  output reg [3:0] trace_status_lines_o,
  output reg [3:0] trace_data_lines_o,
  // local bus fill writes
  output reg bus_req_o,
  output reg [31:0] bus_addr_o,
  output reg [31:0] bus_wdata_o,
  output reg [1:0] bus_size_o,
  input wire bus_ack_i,
  input wire bus_err_i,
  // special control-register cycle
  output reg creg_req_o,
  output reg [31:0] creg_sel_o,
  input wire creg_ack_i,
  input wire [31:0] creg_rdata_i,
  // avalon slave
  input wire [AW-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o
);

  localparam S_IDLE = 3'h0;
  localparam S_OPND = 3'h1;
  localparam S_FILL = 3'h2;
  localparam S_CREG = 3'h3;
  localparam S_SYNC = 3'h4;
  localparam S_TRACE = 3'h5;
  localparam S_RESLO = 3'h6;

  // ***************************************
  // link pin synchronisers
  // ***************************************
  reg [2:0] ck_sync_reg;
  reg [2:0] di_sync_reg;
  reg ck_filt_reg;
  reg di_filt_reg;
  wire ck_rise;
  // a level counts only when stages two and three agree
  assign ck_rise = (ck_sync_reg[2] == ck_sync_reg[1]) & ck_sync_reg[2] &
                   ~ck_filt_reg;

  always @(posedge clk_i) begin
    if (srst_i) begin
      ck_sync_reg <= 3'h0;
      di_sync_reg <= 3'h0;
      ck_filt_reg <= 1'b0;
      di_filt_reg <= 1'b0;
    end else begin
      ck_sync_reg <= {ck_sync_reg[1:0], dsclk_i};
      di_sync_reg <= {di_sync_reg[1:0], dsi_i};
      if (ck_sync_reg[2] == ck_sync_reg[1])
        ck_filt_reg <= ck_sync_reg[2];
      if (di_sync_reg[2] == di_sync_reg[1])
        di_filt_reg <= di_sync_reg[2];
    end
  end

  // ***************************************
  // frame shifter
  // ***************************************
  reg [16:0] rx_reg;
  reg [16:0] tx_reg;
  reg [4:0] bit_cnt_reg;
  reg frame_done_reg;
  reg [16:0] resp_reg;
  wire [16:0] rx_next;
  assign rx_next = {rx_reg[15:0], di_filt_reg};

  // the answer is latched while the link is between frames so that
  // its top bit already stands before the first shift edge
  always @(posedge clk_i) begin
    if (srst_i) begin
      rx_reg <= 17'h00000;
      tx_reg <= `DSCU_RSP_NOTREADY;
      bit_cnt_reg <= 5'h00;
      frame_done_reg <= 1'b0;
      dso_o <= 1'b1;
    end else begin
      frame_done_reg <= 1'b0;
      if (ck_rise) begin
        rx_reg <= rx_next;
        tx_reg <= {tx_reg[15:0], 1'b0};
        if (bit_cnt_reg == `DSCU_FRAME_BITS - 5'h01) begin
          bit_cnt_reg <= 5'h00;
          frame_done_reg <= 1'b1;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end else if (bit_cnt_reg == 5'h00) begin
        tx_reg <= resp_reg;
      end
      dso_o <= tx_reg[16];
    end
  end

  // ***************************************
  // command decoder
  // ***************************************
  reg [2:0] state_reg;
  reg [15:0] cmd_reg;
  reg [1:0] opnd_left_reg;
  reg [31:0] opnd_reg;
  reg fill_ok_reg;
  reg [31:0] ptr_reg;
  reg [15:0] res_lo_reg;
  reg [31:0] pc_cap_reg;
  reg [3:0] nib_left_reg;
  reg [1:0] btb_reg;
  reg [31:0] sp_act_reg;
  reg [31:0] sp_inact_reg;
  wire [15:0] word;
  wire is_fill;
  wire [1:0] wsize;
  wire [1:0] btb_eff;
  wire [11:0] sel_fld;
  assign word = rx_reg[15:0];
  assign wsize = word[`DSCU_SIZE_MSB:`DSCU_SIZE_LSB];
  // the size field is looked at afresh for each fill
  assign is_fill = (word[15:8] == `DSCU_FILL_HI) & (word[5:0] == 6'h00) &
                   (wsize != 2'h3);
  assign btb_eff = (btb_reg == 2'h0) ? 2'h3 : btb_reg;
  assign sel_fld = opnd_reg[11:0];

  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= S_IDLE;
      cmd_reg <= 16'h0000;
      opnd_left_reg <= 2'h0;
      opnd_reg <= 32'h00000000;
      fill_ok_reg <= 1'b0;
      ptr_reg <= 32'h00000000;
      res_lo_reg <= 16'h0000;
      pc_cap_reg <= 32'h00000000;
      nib_left_reg <= 4'h0;
      resp_reg <= `DSCU_RSP_NOTREADY;
      resume_o <= 1'b0;
      pc_sync_req_o <= 1'b0;
      trace_status_lines_o <= `DSCU_TRC_IDLE;
      trace_data_lines_o <= 4'h0;
      bus_req_o <= 1'b0;
      bus_addr_o <= 32'h00000000;
      bus_wdata_o <= 32'h00000000;
      bus_size_o <= 2'h0;
      creg_req_o <= 1'b0;
      creg_sel_o <= 32'h00000000;
    end else begin
      resume_o <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (frame_done_reg && !ext_cmd_busy_i) begin
            cmd_reg <= word;
            opnd_reg <= 32'h00000000;
            if (word == `DSCU_CMD_NOP) begin
              // pointer and legality kept for padding
              resp_reg <= `DSCU_RSP_DONE;
            end else if (word == `DSCU_CMD_GO) begin
              fill_ok_reg <= 1'b0;
              // only a halted core is restarted
              resume_o <= halted_i;
              resp_reg <= `DSCU_RSP_DONE;
            end else if (word == `DSCU_CMD_SYNC) begin
              fill_ok_reg <= 1'b0;
              pc_sync_req_o <= 1'b1;
              resp_reg <= `DSCU_RSP_NOTREADY;
              state_reg <= S_SYNC;
            end else if (word == `DSCU_CMD_RCREG) begin
              fill_ok_reg <= 1'b0;
              opnd_left_reg <= 2'h2;
              resp_reg <= `DSCU_RSP_NOTREADY;
              state_reg <= S_OPND;
            end else if (is_fill) begin
              if (fill_ok_reg) begin
                // long operands take two words, others one
                opnd_left_reg <= (wsize == `DSCU_SIZE_LONG) ? 2'h2 : 2'h1;
                resp_reg <= `DSCU_RSP_NOTREADY;
                state_reg <= S_OPND;
              end else begin
                resp_reg <= `DSCU_RSP_ILLEGAL;
              end
            end else begin
              // commands of the neighbour units end a fill run
              fill_ok_reg <= 1'b0;
            end
          end
        end
        S_OPND: begin
          if (frame_done_reg) begin
            opnd_reg <= {opnd_reg[15:0], word};
            opnd_left_reg <= opnd_left_reg - 2'h1;
            if (opnd_left_reg == 2'h1) begin
              if (cmd_reg == `DSCU_CMD_RCREG) begin
                creg_sel_o <= {opnd_reg[15:0], word};
                state_reg <= S_CREG;
              end else begin
                bus_req_o <= 1'b1;
                bus_addr_o <= ptr_reg;
                bus_size_o <= cmd_reg[`DSCU_SIZE_MSB:`DSCU_SIZE_LSB];
                // byte data sits in the low byte of its word
                if (cmd_reg[`DSCU_SIZE_MSB:`DSCU_SIZE_LSB] ==
                    `DSCU_SIZE_BYTE)
                  bus_wdata_o <= {24'h000000, word[7:0]};
                else if (cmd_reg[`DSCU_SIZE_MSB:`DSCU_SIZE_LSB] ==
                         `DSCU_SIZE_WORD)
                  bus_wdata_o <= {16'h0000, word};
                else
                  bus_wdata_o <= {opnd_reg[15:0], word};
                state_reg <= S_FILL;
              end
            end
          end
        end
        S_FILL: begin
          if (bus_ack_i || bus_err_i) begin
            bus_req_o <= 1'b0;
            state_reg <= S_IDLE;
            if (bus_err_i) begin
              resp_reg <= `DSCU_RSP_BUSERR;
            end else begin
              resp_reg <= `DSCU_RSP_DONE;
              // advance by the size of this very fill
              if (bus_size_o == `DSCU_SIZE_BYTE)
                ptr_reg <= ptr_reg + 32'h00000001;
              else if (bus_size_o == `DSCU_SIZE_WORD)
                ptr_reg <= ptr_reg + 32'h00000002;
              else
                ptr_reg <= ptr_reg + 32'h00000004;
            end
          end
        end
        S_CREG: begin
          // stack pointer codes are served locally, the rest by a
          // special cycle decoded as move-to-control does
          if (sel_fld == `DSCU_SEL_OTHER_SP) begin
            resp_reg <= {1'b0, sp_inact_reg[31:16]};
            res_lo_reg <= sp_inact_reg[15:0];
            state_reg <= S_RESLO;
          end else if (sel_fld == `DSCU_SEL_LOAD_SP ||
                       sel_fld == `DSCU_SEL_STORE_SP) begin
            resp_reg <= {1'b0, sp_act_reg[31:16]};
            res_lo_reg <= sp_act_reg[15:0];
            state_reg <= S_RESLO;
          end else if (creg_req_o && creg_ack_i) begin
            // registers of the core, mac and base groups
            creg_req_o <= 1'b0;
            resp_reg <= {1'b0, creg_rdata_i[31:16]};
            res_lo_reg <= creg_rdata_i[15:0];
            state_reg <= S_RESLO;
          end else begin
            creg_req_o <= 1'b1;
          end
        end
        S_RESLO: begin
          // whatever the host shifts in meanwhile is not a command
          if (frame_done_reg) begin
            resp_reg <= {1'b0, res_lo_reg};
            state_reg <= S_IDLE;
          end
        end
        S_SYNC: begin
          if (pc_capture_i) begin
            pc_sync_req_o <= 1'b0;
            pc_cap_reg <= pc_capture_addr_i;
            trace_status_lines_o <= `DSCU_TRC_TAKEN;
            nib_left_reg <= {1'b0, btb_eff, 1'b0} + 4'h2;
            state_reg <= S_TRACE;
          end
        end
        S_TRACE: begin
          if (trace_status_lines_o == `DSCU_TRC_TAKEN) begin
            // marker 0x9..0xB chosen by the byte count
            trace_status_lines_o <= `DSCU_TRC_MARK_BASE + {2'h0, btb_eff};
          end else if (nib_left_reg != 4'h0) begin
            trace_status_lines_o <= `DSCU_TRC_IDLE;
            trace_data_lines_o <= pc_cap_reg[3:0];
            pc_cap_reg <= {4'h0, pc_cap_reg[31:4]};
            nib_left_reg <= nib_left_reg - 4'h1;
          end else begin
            trace_data_lines_o <= 4'h0;
            resp_reg <= `DSCU_RSP_DONE;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      // a successful fill keeps the run legal
      if (state_reg == S_FILL && bus_ack_i && !bus_err_i)
        fill_ok_reg <= 1'b1;
      // neighbour write seeds the pointer; last, so set beats clear
      if (ext_write_done_i) begin
        fill_ok_reg <= 1'b1;
        ptr_reg <= ext_next_addr_i;
      end
    end
  end

  // ***************************************
  // avalon slave
  // ***************************************
  reg [31:0] rd_mux;
  always @* begin
    case (avs_address_i)
      `DSCU_ADR_CTRL: rd_mux = {30'h00000000, btb_reg};
      `DSCU_ADR_STATUS: rd_mux = {24'h000000, halted_i, supervisor_bit_i,
                                  fill_ok_reg, 2'h0, state_reg};
      `DSCU_ADR_PTR: rd_mux = ptr_reg;
      `DSCU_ADR_SP_ACT: rd_mux = sp_act_reg;
      `DSCU_ADR_SP_INACT: rd_mux = sp_inact_reg;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // one wait cycle: the answer is taken at the second edge of a request
  always @(posedge clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      btb_reg <= `DSCU_CTRL_RST;
      sp_act_reg <= `DSCU_SP_RST;
      sp_inact_reg <= `DSCU_SP_RST;
    end else begin
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= avs_read_i ? rd_mux : 32'h00000000;
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
      // the supervisor bit only shows in status and picks no pointer,
      // the registers themselves never swap
      if (avs_write_i && !avs_waitrequest_o) begin
        if (avs_address_i == `DSCU_ADR_CTRL)
          btb_reg <= avs_writedata_i[1:0];
        if (avs_address_i == `DSCU_ADR_SP_ACT)
          sp_act_reg <= avs_writedata_i;
        if (avs_address_i == `DSCU_ADR_SP_INACT)
          sp_inact_reg <= avs_writedata_i;
      end
    end
  end

endmodule

/* bench/dscu_host.sv */
// host model that drives the debug serial link
`timescale 1ns/1ps
module dscu_host(
  input wire clk_i,
  input wire dso_i,
  output reg dsclk_o,
  output reg dsi_o
);
  initial begin
    dsclk_o = 1'b0;
    dsi_o = 1'b0;
  end
  // one frame of 17 bits, status bit 0 then the word msb first
  // the clock only runs inside a frame; call just after a clock edge
  task frame(input [15:0] w, output [16:0] q);
    integer i;
    reg [16:0] tx;
    begin
      tx = {1'b0, w};
      for (i = 16; i >= 0; i = i - 1) begin
        dsi_o <= tx[i];
        repeat (4) @(posedge clk_i);
        q[i] = dso_i;
        dsclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        dsclk_o <= 1'b0;
      end
      // released line shows the inverse so a stale bit is never trusted
      dsi_o <= ~tx[0];
    end
  endtask
endmodule

/* bench/dscu_sva.sv */
// port assertions of the debug command unit
`timescale 1ns/1ps
module dscu_sva(
  input wire clk_i,
  input wire srst_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire avs_waitrequest_o,
  input wire halted_i,
  input wire resume_o,
  input wire pc_sync_req_o,
  input wire pc_capture_i,
  input wire [3:0] trace_status_lines_o,
  input wire bus_req_o,
  input wire [31:0] bus_addr_o,
  input wire [31:0] bus_wdata_o,
  input wire [1:0] bus_size_o,
  input wire bus_ack_i,
  input wire bus_err_i,
  input wire creg_req_o,
  input wire [31:0] creg_sel_o,
  input wire creg_ack_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // capture seen, then taken code and a marker in the next cycles
  sequence s_capture;
    pc_sync_req_o && pc_capture_i;
  endsequence
  sequence s_marker;
    trace_status_lines_o == 4'h5 ##1
      trace_status_lines_o inside {4'h9, 4'hA, 4'hB};
  endsequence
  a_avs_one_wait: assert property (
    $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("avalon wait count wrong");
  a_fill_hold: assert property (
    bus_req_o && !bus_ack_i && !bus_err_i |=> bus_req_o &&
    $stable(bus_addr_o) && $stable(bus_wdata_o))
    else $error("fill write not held");
  a_fill_size: assert property (
    bus_req_o |-> bus_size_o != 2'h3) else $error("bad fill size");
  a_resume_halted: assert property (
    resume_o |-> $past(halted_i)) else $error("resume while running");
  a_sync_pending: assert property (
    pc_sync_req_o && !pc_capture_i |=> pc_sync_req_o)
    else $error("sync request dropped");
  a_sync_trace: assert property (
    s_capture |=> s_marker) else $error("trace sequence wrong");
  a_creg_hold: assert property (
    creg_req_o && !creg_ack_i |=> creg_req_o && $stable(creg_sel_o))
    else $error("control cycle not held");
  a_creg_select: assert property (
    creg_req_o |-> creg_sel_o[31:12] == 20'h00000)
    else $error("select wider than 12 bits");
endmodule
bind dscu_top dscu_sva u_dscu_sva(.clk_i(clk_i), .srst_i(srst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .halted_i(halted_i),
  .resume_o(resume_o), .pc_sync_req_o(pc_sync_req_o),
  .pc_capture_i(pc_capture_i),
  .trace_status_lines_o(trace_status_lines_o), .bus_req_o(bus_req_o),
  .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o),
  .bus_size_o(bus_size_o), .bus_ack_i(bus_ack_i), .bus_err_i(bus_err_i),
  .creg_req_o(creg_req_o), .creg_sel_o(creg_sel_o),
  .creg_ack_i(creg_ack_i));

/* bench/tb.sv */
// self-checking bench of the debug command unit
`timescale 1ns/1ps
`include "dscu_map.vh"
module tb;
  reg clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg halted = 1'b0, sup = 1'b0, cap = 1'b0, wdone = 1'b0;
  reg ack = 1'b0, err = 1'b0, cack = 1'b0, emode = 1'b0;
  reg rd = 1'b0, wr = 1'b0;
  reg [2:0] adr = 3'h0;
  reg [31:0] naddr = 32'h0, wdat = 32'h0, crd = 32'h0;
  reg [31:0] la, lwd, lsel, v;
  reg [1:0] lsz;
  reg [16:0] r;
  wire dsclk, dsi, dso, resume, sreq, breq, creq, wreq;
  wire [3:0] tst, tdt;
  wire [1:0] bsz;
  wire [31:0] baddr, bwd, csel, rdat;
  integer fails = 0, tests_run = 0, cyc = 0, nres = 0, nev = 0;
  localparam [31:0] PC = 32'h1234ABCD;
  dscu_top u_dscu_top(.clk_i(clk_i), .srst_i(srst_i), .dsclk_i(dsclk),
    .dsi_i(dsi), .dso_o(dso), .ext_cmd_busy_i(1'b0),
    .ext_write_done_i(wdone), .ext_next_addr_i(naddr), .halted_i(halted),
    .supervisor_bit_i(sup), .resume_o(resume), .pc_sync_req_o(sreq),
    .pc_capture_i(cap), .pc_capture_addr_i(PC),
    .trace_status_lines_o(tst), .trace_data_lines_o(tdt),
    .bus_req_o(breq), .bus_addr_o(baddr), .bus_wdata_o(bwd),
    .bus_size_o(bsz), .bus_ack_i(ack), .bus_err_i(err),
    .creg_req_o(creq), .creg_sel_o(csel), .creg_ack_i(cack),
    .creg_rdata_i(crd), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq));
  dscu_host u_host(.clk_i(clk_i), .dso_i(dso), .dsclk_o(dsclk),
    .dsi_o(dsi));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // far side: bus, control cycle and core each answer one cycle late
  always @(posedge clk_i) begin
    ack <= breq && !ack && !err && !emode;
    err <= breq && !ack && !err && emode;
    cack <= creq && !cack;
    crd <= ~csel;
    cap <= sreq && !cap;
    cyc <= cyc + 1;
    if (breq) begin
      la <= baddr;
      lwd <= bwd;
      lsz <= bsz;
    end
    if (creq) lsel <= csel;
    if (ack || err || cack) nev <= nev + 1;
    if (resume === 1'b1) nres <= nres + 1;
    // whole run needs about 8000 cycles
    if (cyc == 30000) begin
      fails = fails + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task avs(input w, input [2:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      n = 0;
      @(posedge clk_i);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) chk("avs_wait", 0, 1);
    end
  endtask
  // wait for the far side to finish a cycle, bounded
  task settle(input integer n0, input need);
    integer n;
    begin
      n = 0;
      while (nev == n0 && n < 100) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (need && n >= 100) chk("answer", 0, 1);
      repeat (2) @(posedge clk_i);
    end
  endtask
  task fill(input [7:0] lo, input [31:0] d, input [16:0] er,
    input [31:0] ea);
    integer n0;
    reg [31:0] m;
    begin
      n0 = nev;
      m = lo == 8'h00 ? 32'hFF : lo == 8'h40 ? 32'hFFFF : 32'hFFFFFFFF;
      u_host.frame({`DSCU_FILL_HI, lo}, r);
      if (lo == 8'h80) u_host.frame(d[31:16], r);
      u_host.frame(d[15:0], r);
      settle(n0, 1'b1);
      u_host.frame(`DSCU_CMD_NOP, r); // padding between fills
      chk("fill_rsp", r, er);
      chk("fill_addr", la, ea);
      chk("fill_size", lsz, lo[7:6]);
      chk("fill_data", lwd & m, d & m);
    end
  endtask
  task creg(input [11:0] s, input [31:0] e, input need);
    integer n0;
    begin
      n0 = nev;
      u_host.frame(`DSCU_CMD_RCREG, r);
      u_host.frame(16'h0000, r);
      u_host.frame({4'h0, s}, r);
      settle(n0, need);
      u_host.frame(`DSCU_CMD_NOP, r);
      chk("creg_hi", r, {1'b0, e[31:16]});
      u_host.frame(`DSCU_CMD_NOP, r);
      chk("creg_lo", r, {1'b0, e[15:0]});
      if (need) chk("creg_sel", lsel, {20'h0, s});
    end
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task t_regs;
    begin
      avs(1'b0, `DSCU_ADR_CTRL, 32'h0, v);
      chk("ctrl_rst", v, {30'h0, `DSCU_CTRL_RST});
      avs(1'b0, 3'h7, 32'h0, v);
      chk("hole", v, 32'h0);
      avs(1'b1, `DSCU_ADR_CTRL, 32'h1, v);
      avs(1'b1, `DSCU_ADR_SP_ACT, 32'h11110000, v);
      avs(1'b1, `DSCU_ADR_SP_INACT, 32'h22220000, v);
      avs(1'b0, `DSCU_ADR_CTRL, 32'h0, v);
      chk("ctrl_rw", v, 32'h1);
      sup <= 1'b1;
      avs(1'b0, `DSCU_ADR_STATUS, 32'h0, v);
      chk("sup_bit", v[6], 1'b1);
    end
  endtask
  task t_fill;
    integer n0;
    begin
      n0 = nev;
      u_host.frame({`DSCU_FILL_HI, 8'h40}, r);
      u_host.frame(`DSCU_CMD_NOP, r);
      chk("fill_illegal", r, `DSCU_RSP_ILLEGAL);
      chk("fill_nowrite", nev, n0);
      wdone <= 1'b1;
      naddr <= 32'h103;
      @(posedge clk_i);
      wdone <= 1'b0;
      fill(8'h00, 32'hFFAB, `DSCU_RSP_DONE, 32'h103);
      fill(8'h80, 32'hDEADBEEF, `DSCU_RSP_DONE, 32'h104);
      fill(8'h40, 32'hBEEF, `DSCU_RSP_DONE, 32'h108);
      emode <= 1'b1;
      fill(8'h40, 32'h5555, `DSCU_RSP_BUSERR, 32'h10A);
      emode <= 1'b0;
      avs(1'b0, `DSCU_ADR_PTR, 32'h0, v);
      chk("ptr", v, 32'h10A);
    end
  endtask
  task t_go;
    integer n0;
    begin
      halted <= 1'b1;
      n0 = nres;
      u_host.frame(`DSCU_CMD_GO, r);
      u_host.frame(`DSCU_CMD_NOP, r);
      chk("go_done", r, `DSCU_RSP_DONE);
      chk("go_pulse", nres - n0, 1);
      halted <= 1'b0;
      u_host.frame(`DSCU_CMD_GO, r);
      u_host.frame(`DSCU_CMD_NOP, r);
      chk("go_idle", nres - n0, 1);
      u_host.frame(`DSCU_CMD_NOP, r);
      chk("nop_done", r, `DSCU_RSP_DONE);
    end
  endtask
  task t_sync;
    integer i;
    begin
      u_host.frame(`DSCU_CMD_SYNC, r);
      // request stands from the first edge after the frame ends
      repeat (2) @(posedge clk_i);
      chk("sync_req", sreq, 1'b1);
      i = 0;
      while (tst !== 4'h5 && i < 200) begin
        @(posedge clk_i);
        i = i + 1;
      end
      chk("taken", tst, 4'h5);
      @(posedge clk_i);
      chk("marker", tst, 4'h9);
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk_i);
        chk("pc_nib", {tst, tdt}, {4'h0, PC[4*i +: 4]});
      end
      repeat (4) @(posedge clk_i);
      u_host.frame(`DSCU_CMD_NOP, r);
      chk("sync_done", r, `DSCU_RSP_DONE);
    end
  endtask
  task t_creg;
    begin
      creg(12'h009, ~32'h009, 1'b1);
      creg(12'hC05, ~32'hC05, 1'b1);
      creg(12'h806, ~32'h806, 1'b1);
      creg(12'h80F, ~32'h80F, 1'b1);
      creg(12'h187, ~32'h187, 1'b1);
      creg(`DSCU_SEL_OTHER_SP, 32'h22220000, 1'b0);
      creg(`DSCU_SEL_LOAD_SP, 32'h11110000, 1'b0);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_regs;
    t_fill;
    t_go;
    t_sync;
    t_creg;
    give_verdict;
  end
endmodule
